/* File: hw/clp_codec_link.sv */
// Codec serial link, pin control and register file behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module clp_codec_link
   import clp_pkg::*;
#(
   // Arbitrary identification values
   parameter logic [15:0] VENDOR_ID1 = 16'h0001,
   parameter logic [15:0] VENDOR_ID2 = 16'h0002
)
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // AXI4-Lite write
   input wire logic [CLP_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [CLP_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Serial link
   input wire logic BIT_CLK_I,
   output logic BIT_CLK_O,
   output logic BIT_CLK_OE_N,
   input wire logic LINK_SYNC,
   input wire logic SER_FROM_CTRL,
   output logic SER_TO_CTRL,
   input wire logic LINK_RESET_N,
   input wire logic CHAIN_IN,
   // Crystal
   input wire logic CRYSTAL_INPUT,
   output logic CRYSTAL_OUTPUT,
   // Address straps
   input wire logic ADDR_STRAP_LSB,
   input wire logic ADDR_STRAP_MSB,
   // Analog controls
   output logic EXT_AMP_POWERDOWN,
   output logic STEREO_WIDEN_EN,
   output logic MIC_BOOST_EN,
   output logic MIC_SELECT_B,
   output logic MONO_FROM_MIC,
   output logic [15:0] LINE_OUT_LVL,
   output logic [15:0] HEADPHONE_LVL,
   output logic [15:0] MONO_OUT_LVL,
   output logic [15:0] MIC_MIX_LVL,
   output logic [15:0] LINE_IN_MIX_LVL,
   output logic [15:0] CD_MIX_LVL,
   output logic [15:0] VIDEO_MIX_LVL
);
   logic [15:0] regs_q [CLP_NSLOT];
   logic [1:0] codec_addr_q;
   logic fwd_q;
   logic [7:0] frame_cnt_q;

   // Pin synchroniser
   clp_pin_if #(.W(CLP_PIN_COUNT)) pins (.clk(MCLK), .rst(SRST));
   assign pins.raw = {ADDR_STRAP_MSB, ADDR_STRAP_LSB, CRYSTAL_INPUT,
                      LINK_RESET_N, CHAIN_IN, SER_FROM_CTRL, LINK_SYNC,
                      BIT_CLK_I};
   clp_pin_sync #(.W(CLP_PIN_COUNT), .INIT(CLP_PIN_INIT)) u_sync
   (
      .pins(pins.sync_side)
   );

   wire logic link_rst = ~pins.clean[CLP_PIN_RSTN];
   wire logic lrst = SRST | link_rst;
   wire logic chain_clean = pins.clean[CLP_PIN_CHAIN];
   wire logic is_primary = (codec_addr_q == 2'h0);

   function automatic logic [3:0] slot_of(input logic [6:0] a);
      case (a)
         CLP_REG_MASTER: slot_of = CLP_SLOT_MASTER;
         CLP_REG_HEADPHONE: slot_of = CLP_SLOT_HEADPHONE;
         CLP_REG_MONO: slot_of = CLP_SLOT_MONO;
         CLP_REG_MIC: slot_of = CLP_SLOT_MIC;
         CLP_REG_LINE_IN: slot_of = CLP_SLOT_LINE_IN;
         CLP_REG_CD: slot_of = CLP_SLOT_CD;
         CLP_REG_VIDEO: slot_of = CLP_SLOT_VIDEO;
         CLP_REG_GENERAL: slot_of = CLP_SLOT_GENERAL;
         CLP_REG_POWER: slot_of = CLP_SLOT_POWER;
         CLP_REG_CHAIN: slot_of = CLP_SLOT_CHAIN;
         default: slot_of = CLP_SLOT_NONE;
      endcase
   endfunction

   // Returns hit flag and read value
   function automatic logic [16:0] read_word(input logic [6:0] a);
      logic [3:0] s;
      begin
         s = slot_of(a);
         if (s == CLP_SLOT_POWER)
            read_word = {1'b1, regs_q[s] | CLP_PD_READY};
         else if (s != CLP_SLOT_NONE)
            read_word = {1'b1, regs_q[s]};
         else
            case (a)
               CLP_REG_WIDEN: read_word = {1'b1, 16'h0000};
               CLP_REG_VENDOR1: read_word = {1'b1, VENDOR_ID1};
               CLP_REG_VENDOR2: read_word = {1'b1, VENDOR_ID2};
               CLP_REG_LINK_STAT:
                  read_word = {1'b1, frame_cnt_q, 4'h0, fwd_q,
                               ~is_primary, codec_addr_q};
               default: read_word = {1'b0, 16'h0000};
            endcase
      end
   endfunction

   // Strap capture after reset release
   clp_strap_type strap_state_q;
   logic [2:0] settle_q;
   wire logic strap_take = (strap_state_q == CAPTURE_SETTLE) &&
                           (settle_q == CLP_STRAP_SETTLE - 3'h1);

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         strap_state_q <= CAPTURE_IDLE;
         settle_q <= 3'h0;
      end
      else
         case (strap_state_q)
            CAPTURE_IDLE:
            begin
               strap_state_q <= CAPTURE_SETTLE;
               settle_q <= 3'h0;
            end
            CAPTURE_SETTLE:
            begin
               settle_q <= settle_q + 3'h1;
               if (strap_take)
                  strap_state_q <= CAPTURE_DONE;
            end
            CAPTURE_DONE: strap_state_q <= CAPTURE_DONE;
            default: strap_state_q <= CAPTURE_IDLE;
         endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
         codec_addr_q <= 2'h0;
      else if (strap_take)
         codec_addr_q <= ~{pins.clean[CLP_PIN_STRAP_M],
                           pins.clean[CLP_PIN_STRAP_L]};
   end

   // Bit clock from halved crystal, or from the pin
   logic xtal_prev_q;
   logic bclk_gen_q;
   logic bclk_prev_q;
   wire logic xtal_rise = pins.clean[CLP_PIN_XTAL] & ~xtal_prev_q;

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         xtal_prev_q <= 1'b0;
         bclk_gen_q <= 1'b0;
         CRYSTAL_OUTPUT <= 1'b1;
      end
      else
      begin
         xtal_prev_q <= pins.clean[CLP_PIN_XTAL];
         CRYSTAL_OUTPUT <= ~pins.clean[CLP_PIN_XTAL];
         if (xtal_rise)
            bclk_gen_q <= ~bclk_gen_q;
      end
   end

   assign BIT_CLK_O = is_primary & bclk_gen_q;
   assign BIT_CLK_OE_N = ~is_primary;
   wire logic bclk_int = is_primary ? bclk_gen_q
                                    : pins.clean[CLP_PIN_BCLK];
   wire logic bclk_rise = bclk_int & ~bclk_prev_q;
   wire logic bclk_fall = ~bclk_int & bclk_prev_q;

   always_ff @(posedge MCLK)
   begin
      if (SRST)
         bclk_prev_q <= 1'b0;
      else
         bclk_prev_q <= bclk_int;
   end

   // Receive side: sampled on falling bit clock edges
   logic sync_prev_q;
   logic [5:0] rx_cnt_q;
   logic [54:0] rx_shift_q;
   logic link_wr_q;
   logic [6:0] link_addr_q;
   logic [15:0] link_data_q;
   logic rd_pend_q;
   logic [6:0] rd_addr_q;
   wire logic frame_start = bclk_fall & pins.clean[CLP_PIN_SYNC] &
                            ~sync_prev_q;
   wire logic [55:0] head_w = {rx_shift_q, pins.clean[CLP_PIN_SDATA]};
   wire logic head_done = bclk_fall & ~frame_start &
                          (rx_cnt_q == CLP_HEAD_LAST);
   wire logic [15:0] tag_w = head_w[55:40];
   wire logic [19:0] s1_w = head_w[39:20];
   wire logic [19:0] s2_w = head_w[19:0];

   always_ff @(posedge MCLK)
   begin
      if (lrst)
      begin
         sync_prev_q <= 1'b0;
         rx_cnt_q <= CLP_HEAD_BITS;
         rx_shift_q <= '0;
      end
      else if (bclk_fall)
      begin
         sync_prev_q <= pins.clean[CLP_PIN_SYNC];
         if (frame_start)
            rx_cnt_q <= 6'h0;
         else if (rx_cnt_q != CLP_HEAD_BITS)
         begin
            rx_shift_q <= head_w[54:0];
            rx_cnt_q <= rx_cnt_q + 6'h1;
         end
      end
   end

   // Control slot decode at the end of the data slot
   always_ff @(posedge MCLK)
   begin
      if (lrst)
      begin
         link_wr_q <= 1'b0;
         link_addr_q <= 7'h00;
         link_data_q <= 16'h0000;
         rd_pend_q <= 1'b0;
         rd_addr_q <= 7'h00;
      end
      else
      begin
         link_wr_q <= 1'b0;
         if (frame_start)
            rd_pend_q <= 1'b0;
         if (head_done && tag_w[CLP_TAG_VALID] && tag_w[CLP_TAG_ADDR])
         begin
            if (s1_w[CLP_S1_READ])
            begin
               rd_pend_q <= 1'b1;
               rd_addr_q <= s1_w[18:12];
            end
            else if (tag_w[CLP_TAG_DATA])
            begin
               link_wr_q <= 1'b1;
               link_addr_q <= s1_w[18:12];
               link_data_q <= s2_w[19:4];
            end
         end
      end
   end

   // Transmit side: launched on rising bit clock edges
   logic [55:0] tx_shift_q;
   logic out_q;
   wire logic [16:0] rd_word = read_word(rd_addr_q);

   always_ff @(posedge MCLK)
   begin
      if (lrst)
      begin
         tx_shift_q <= '0;
         out_q <= 1'b0;
         fwd_q <= 1'b0;
         frame_cnt_q <= 8'h00;
      end
      else if (frame_start)
      begin
         tx_shift_q <= {1'b1, rd_pend_q, rd_pend_q, 13'h0000,
                        1'b0, rd_addr_q, 12'h000,
                        rd_word[15:0], 4'h0};
         fwd_q <= regs_q[CLP_SLOT_CHAIN][1:0] != codec_addr_q;
         frame_cnt_q <= frame_cnt_q + 8'h01;
      end
      else if (bclk_rise)
      begin
         out_q <= fwd_q ? chain_clean : tx_shift_q[55];
         tx_shift_q <= {tx_shift_q[54:0], 1'b0};
      end
   end

   assign SER_TO_CTRL = out_q;

   // AXI4-Lite slave
   logic aw_full_q;
   logic [CLP_AXI_AW-1:0] aw_addr_q;
   logic w_full_q;
   logic [15:0] w_data_q;
   logic [1:0] w_strb_q;
   logic [15:0] rdata_q;
   wire logic axi_wr_go = aw_full_q & w_full_q & ~S_AXI_BVALID & ~link_wr_q;
   wire logic [6:0] aw_index = aw_addr_q[8:2];
   wire logic [6:0] ar_index = S_AXI_ARADDR[8:2];
   wire logic [16:0] aw_word = read_word(aw_index);
   wire logic [16:0] ar_word = read_word(ar_index);

   assign S_AXI_AWREADY = ~aw_full_q;
   assign S_AXI_WREADY = ~w_full_q;
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign S_AXI_RDATA = {16'h0000, rdata_q};

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q <= 1'b0;
         w_data_q <= 16'h0000;
         w_strb_q <= 2'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= CLP_RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_full_q)
         begin
            aw_full_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_full_q)
         begin
            w_full_q <= 1'b1;
            w_data_q <= S_AXI_WDATA[15:0];
            w_strb_q <= S_AXI_WSTRB[1:0];
         end
         if (axi_wr_go)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (aw_word[16] && aw_addr_q[1:0] == 2'h0) ?
                           CLP_RESP_OKAY : CLP_RESP_SLVERR;
         end
         else if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         S_AXI_RVALID <= 1'b0;
         rdata_q <= 16'h0000;
         S_AXI_RRESP <= CLP_RESP_OKAY;
      end
      else if (S_AXI_ARVALID && !S_AXI_RVALID)
      begin
         S_AXI_RVALID <= 1'b1;
         rdata_q <= ar_word[15:0];
         S_AXI_RRESP <= (ar_word[16] && S_AXI_ARADDR[1:0] == 2'h0) ?
                        CLP_RESP_OKAY : CLP_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end

   // Register file; link writes take the cycle, the bus waits one
   wire logic [3:0] wr_slot = link_wr_q ? slot_of(link_addr_q)
                                        : slot_of(aw_index);
   wire logic [15:0] wr_data = link_wr_q ? link_data_q : w_data_q;
   wire logic [15:0] wr_lanes = link_wr_q ? 16'hFFFF :
                                {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire logic wr_en = link_wr_q | (axi_wr_go & (aw_addr_q[1:0] == 2'h0));

   always_ff @(posedge MCLK)
   begin
      if (lrst)
      begin
         for (int i = 0; i < CLP_NSLOT; i++)
            regs_q[i] <= CLP_DEFAULT[i];
      end
      else if (wr_en && wr_slot != CLP_SLOT_NONE)
         regs_q[wr_slot] <= (regs_q[wr_slot] &
                             ~(CLP_MASK[wr_slot] & wr_lanes)) |
                            (wr_data & CLP_MASK[wr_slot] & wr_lanes);
   end

   // Analog control outputs
   assign EXT_AMP_POWERDOWN = regs_q[CLP_SLOT_POWER][CLP_EXT_AMP_POWERDOWN_BIT];
   assign STEREO_WIDEN_EN = regs_q[CLP_SLOT_GENERAL][CLP_WIDEN_BIT];
   assign MIC_BOOST_EN = regs_q[CLP_SLOT_MIC][CLP_MIC_BOOST_BIT];
   assign MIC_SELECT_B = regs_q[CLP_SLOT_GENERAL][CLP_MIC_SEL_BIT];
   assign MONO_FROM_MIC = regs_q[CLP_SLOT_GENERAL][CLP_MONO_SRC_BIT];
   assign LINE_OUT_LVL = regs_q[CLP_SLOT_MASTER];
   assign HEADPHONE_LVL = regs_q[CLP_SLOT_HEADPHONE];
   assign MONO_OUT_LVL = regs_q[CLP_SLOT_MONO];
   assign MIC_MIX_LVL = regs_q[CLP_SLOT_MIC];
   assign LINE_IN_MIX_LVL = regs_q[CLP_SLOT_LINE_IN];
   assign CD_MIX_LVL = regs_q[CLP_SLOT_CD];
   assign VIDEO_MIX_LVL = regs_q[CLP_SLOT_VIDEO];

   // Checks
   wire logic [159:0] regs_flat = {regs_q[9], regs_q[8], regs_q[7],
      regs_q[6], regs_q[5], regs_q[4], regs_q[3], regs_q[2], regs_q[1],
      regs_q[0]};

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SRST);

   a_rx_fall_only: assert property (
      (!link_rst && !$past(link_rst) && $changed(rx_cnt_q))
      |-> $past(bclk_fall))
      else $error("receive count moved off a falling edge");
   a_tx_rise_only: assert property (
      (!lrst && !$past(lrst) && $changed(out_q)) |-> $past(bclk_rise))
      else $error("output bit moved off a rising edge");
   a_bclk_halved: assert property (
      (!$past(SRST) && $changed(bclk_gen_q)) |-> $past(xtal_rise))
      else $error("bit clock toggled without crystal edge");
   a_frame_restart: assert property (
      (frame_start && !lrst) |=> rx_cnt_q == 6'h0 ##1 !bclk_fall[*2])
      else $error("frame start did not realign receiver");
   a_reset_defaults: assert property (
      link_rst |=> (!EXT_AMP_POWERDOWN && !STEREO_WIDEN_EN &&
                    LINE_OUT_LVL == 16'h8000))
      else $error("link reset left non-default registers");
   a_strap_invert: assert property (
      strap_take |=> codec_addr_q ==
         ~$past(pins.clean[CLP_PIN_STRAP_M:CLP_PIN_STRAP_L]))
      else $error("codec address not inverse of straps");
   a_amp_follows: assert property (
      (axi_wr_go && aw_index == CLP_REG_POWER && aw_addr_q[1:0] == 2'h0 &&
       w_strb_q[1] && !lrst)
      |=> EXT_AMP_POWERDOWN == $past(w_data_q[15]))
      else $error("amplifier powerdown did not follow write");
   a_widen_void: assert property (
      (axi_wr_go && aw_index == CLP_REG_WIDEN && !lrst) |=> $stable(regs_flat))
      else $error("depth register write changed state");
   a_fwd_boundary: assert property (
      $changed(fwd_q) |-> ($past(frame_start) || $past(lrst)))
      else $error("forwarding changed inside a frame");
   a_fwd_select: assert property (
      (fwd_q && bclk_rise && !lrst && !frame_start)
      |=> SER_TO_CTRL == $past(chain_clean))
      else $error("forwarded bit not taken from chain input");

   c_link_write: cover property (link_wr_q);
   c_read_reply: cover property (frame_start && rd_pend_q);
   c_forward_on: cover property ($rose(fwd_q));
   c_axi_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
`default_nettype wire

/* File: shared/clp_pkg.sv */
// Constants, register map and types for the codec link and pin control block
package clp_pkg;
   // Clock rates
   localparam int CLP_MCLK_HZ = 200_000_000;
   localparam int CLP_XTAL_HZ = 24_576_000;
   localparam int CLP_BCLK_HZ = 12_288_000;
   localparam int CLP_BCLK_DIV = CLP_XTAL_HZ / CLP_BCLK_HZ;
   localparam int CLP_FRAME_HZ = 48_000;

   // Register bus
   localparam int CLP_AXI_AW = 9;
   localparam logic [1:0] CLP_RESP_OKAY = 2'h0;
   localparam logic [1:0] CLP_RESP_SLVERR = 2'h2;

   // Codec register indices; byte address is four times the index
   localparam logic [6:0] CLP_REG_MASTER = 7'h02;
   localparam logic [6:0] CLP_REG_HEADPHONE = 7'h04;
   localparam logic [6:0] CLP_REG_MONO = 7'h06;
   localparam logic [6:0] CLP_REG_MIC = 7'h0E;
   localparam logic [6:0] CLP_REG_LINE_IN = 7'h10;
   localparam logic [6:0] CLP_REG_CD = 7'h12;
   localparam logic [6:0] CLP_REG_VIDEO = 7'h14;
   localparam logic [6:0] CLP_REG_GENERAL = 7'h20;
   localparam logic [6:0] CLP_REG_WIDEN = 7'h22;
   localparam logic [6:0] CLP_REG_POWER = 7'h26;
   localparam logic [6:0] CLP_REG_CHAIN = 7'h74;
   localparam logic [6:0] CLP_REG_VENDOR1 = 7'h7C;
   localparam logic [6:0] CLP_REG_VENDOR2 = 7'h7E;
   localparam logic [6:0] CLP_REG_LINK_STAT = 7'h7F;

   // Storage slots
   localparam int CLP_NSLOT = 10;
   localparam logic [3:0] CLP_SLOT_MASTER = 4'h0;
   localparam logic [3:0] CLP_SLOT_HEADPHONE = 4'h1;
   localparam logic [3:0] CLP_SLOT_MONO = 4'h2;
   localparam logic [3:0] CLP_SLOT_MIC = 4'h3;
   localparam logic [3:0] CLP_SLOT_LINE_IN = 4'h4;
   localparam logic [3:0] CLP_SLOT_CD = 4'h5;
   localparam logic [3:0] CLP_SLOT_VIDEO = 4'h6;
   localparam logic [3:0] CLP_SLOT_GENERAL = 4'h7;
   localparam logic [3:0] CLP_SLOT_POWER = 4'h8;
   localparam logic [3:0] CLP_SLOT_CHAIN = 4'h9;
   localparam logic [3:0] CLP_SLOT_NONE = 4'hF;

   localparam logic [15:0] CLP_DEFAULT [CLP_NSLOT] = '{
      16'h8000, 16'h8000, 16'h8000, 16'h8008, 16'h8808,
      16'h8808, 16'h8808, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] CLP_MASK [CLP_NSLOT] = '{
      16'h9F1F, 16'h9F1F, 16'h801F, 16'h805F, 16'h9F1F,
      16'h9F1F, 16'h9F1F, 16'h2380, 16'hFF00, 16'h0003};

   // Field positions
   localparam int CLP_MUTE_BIT = 15;
   localparam int CLP_MIC_BOOST_BIT = 6;
   localparam int CLP_WIDEN_BIT = 13;
   localparam int CLP_MONO_SRC_BIT = 9;
   localparam int CLP_MIC_SEL_BIT = 8;
   localparam int CLP_EXT_AMP_POWERDOWN_BIT = 15;
   localparam logic [15:0] CLP_PD_READY = 16'h000F;

   // Frame layout: tag, control address slot, control data slot
   localparam logic [5:0] CLP_HEAD_BITS = 6'h38;
   localparam logic [5:0] CLP_HEAD_LAST = 6'h37;
   localparam int CLP_TAG_VALID = 15;
   localparam int CLP_TAG_ADDR = 14;
   localparam int CLP_TAG_DATA = 13;
   localparam int CLP_S1_READ = 19;

   // Synchronised pin positions
   localparam int CLP_PIN_COUNT = 8;
   localparam int CLP_PIN_BCLK = 0;
   localparam int CLP_PIN_SYNC = 1;
   localparam int CLP_PIN_SDATA = 2;
   localparam int CLP_PIN_CHAIN = 3;
   localparam int CLP_PIN_RSTN = 4;
   localparam int CLP_PIN_XTAL = 5;
   localparam int CLP_PIN_STRAP_L = 6;
   localparam int CLP_PIN_STRAP_M = 7;
   localparam logic [7:0] CLP_PIN_INIT = 8'hD0;

   // Strap capture
   localparam logic [2:0] CLP_STRAP_SETTLE = 3'h4;
   typedef enum logic [1:0] {
      CAPTURE_IDLE = 2'h0,
      CAPTURE_SETTLE = 2'h1,
      CAPTURE_DONE = 2'h3
   } clp_strap_type;
endpackage

/* File: shared/clp_pin_if.sv */
// Raw and filtered pin levels between the block and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface clp_pin_if #(parameter int W = 8)
(
   input wire logic clk,
   input wire logic rst
);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync_side (input clk, input rst, input raw, output clean);
   modport user_side (output raw, input clean);
endinterface
`default_nettype wire

/* File: hw/clp_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module clp_pin_sync
   import clp_pkg::*;
#(
   parameter int W = CLP_PIN_COUNT,
   parameter logic [W-1:0] INIT = '0
)
(
   clp_pin_if.sync_side pins
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   if (W < 1)
   begin : g_bad_width
      $error("clp_pin_sync needs at least one pin");
   end

   // Level changes once the second and third stages agree
   always_ff @(posedge pins.clk)
   begin
      if (pins.rst)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         pins.clean <= INIT;
      end
      else
      begin
         s1_q <= pins.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pins.clean <= (s2_q & s3_q) | (pins.clean & (s2_q | s3_q));
      end
   end
endmodule
`default_nettype wire

/* File: tb/clp_ctrl_model.sv */
// Controller model: frame sync, outbound stream, inbound capture
`timescale 1ns/1ps
`default_nettype none
module clp_ctrl_model
(
   // Link pins and frame words
   input wire logic BCLK,
   input wire logic SDI,
   input wire logic [55:0] HEAD,
   output var logic SYNC = 1'b0,
   output var logic SDO = 1'b0,
   output var logic [55:0] RX = '0,
   output var logic [7:0] FRAMES = '0
);
   logic [7:0] n_q = 8'hF0;
   logic [55:0] tx_q = '0, sh_q = '0;
   // Sync and data move at bit clock rise
   always @(posedge BCLK)
   begin
      n_q <= n_q + 8'h01;
      SYNC <= n_q == 8'hFF || n_q < 8'h0F;
      tx_q <= n_q == 8'hFF ? HEAD : tx_q;
      SDO <= n_q < 8'h38 ? tx_q[8'h37 - n_q] : n_q[0];
   end
   // Inbound bits taken at bit clock fall
   always @(negedge BCLK)
   begin
      sh_q <= n_q > 8'h00 && n_q < 8'h39 ? {sh_q[54:0], SDI} : sh_q;
      RX <= n_q == 8'h39 ? sh_q : RX;
      FRAMES <= FRAMES + {7'h00, n_q == 8'h39};
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench for the codec link block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import clp_pkg::*;
;
   logic mclk = 0, srst = 1, xtal = 0, rstn = 1, chain = 0, awv = 0, wv = 0;
   logic bready = 0, arv = 0, rready = 0, awr, wrd, bv, arr, rv, bclk, oe_n;
   logic sync, sdo, sdi, ext_amp_powerdown, widen, boost, micb, monom, xo;
   logic strap_l = 1, bclk_ext = 0;
   logic [8:0] awa = '0, ara = '0;
   logic [3:0] ws = 4'hF;
   logic [31:0] wdat = '0, rdat;
   logic [1:0] bresp, rresp, r;
   logic [15:0] d, v, m0;
   logic [15:0] lvl [7];
   logic [55:0] head = '0, rx;
   logic [7:0] frames;
   int failures = 0, comparisons = 0;
   localparam logic [6:0] LV [7] = '{CLP_REG_MASTER, CLP_REG_HEADPHONE,
      CLP_REG_MONO, CLP_REG_MIC, CLP_REG_LINE_IN, CLP_REG_CD, CLP_REG_VIDEO};
   clp_codec_link u_clp_codec_link (.MCLK(mclk), .SRST(srst),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdat), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .BIT_CLK_I(bclk_ext),
      .BIT_CLK_O(bclk), .BIT_CLK_OE_N(oe_n), .LINK_SYNC(sync),
      .SER_FROM_CTRL(sdo), .SER_TO_CTRL(sdi), .LINK_RESET_N(rstn),
      .CHAIN_IN(chain), .CRYSTAL_INPUT(xtal), .CRYSTAL_OUTPUT(xo),
      .ADDR_STRAP_LSB(strap_l), .ADDR_STRAP_MSB(1'b1),
      .EXT_AMP_POWERDOWN(ext_amp_powerdown), .STEREO_WIDEN_EN(widen),
      .MIC_BOOST_EN(boost), .MIC_SELECT_B(micb), .MONO_FROM_MIC(monom),
      .LINE_OUT_LVL(lvl[0]), .HEADPHONE_LVL(lvl[1]), .MONO_OUT_LVL(lvl[2]),
      .MIC_MIX_LVL(lvl[3]), .LINE_IN_MIX_LVL(lvl[4]), .CD_MIX_LVL(lvl[5]),
      .VIDEO_MIX_LVL(lvl[6]));
   clp_ctrl_model u_clp_ctrl_model (.BCLK(oe_n ? bclk_ext : bclk),
      .SDI(sdi), .HEAD(head), .SYNC(sync), .SDO(sdo), .RX(rx),
      .FRAMES(frames));
   initial forever #2.5 mclk = ~mclk;
   initial forever #20.345 xtal = ~xtal;
   initial forever #40.69 bclk_ext = ~bclk_ext;
   task automatic chk(input string n, input logic [55:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [6:0] i, input logic [15:0] x,
      input logic [3:0] s);
      @(posedge mclk);
      {awa, wdat, ws} <= {i, 2'h0, 16'h0000, x, s};
      {awv, wv, bready} <= 3'h7;
      while (!bv)
      begin
         @(posedge mclk);
         {awv, wv} <= {awv && !awr, wv && !wrd};
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] i);
      @(posedge mclk);
      {ara, arv, rready} <= {i, 2'h0, 2'h3};
      while (!rv)
      begin
         @(posedge mclk);
         arv <= arv && !arr;
      end
      {r, d} = {rresp, rdat[15:0]};
      rready <= 1'b0;
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      v = 16'($urandom(45150));
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("pins", {oe_n, ext_amp_powerdown}, 2'h0);
      rd(CLP_REG_LINK_STAT);
      chk("codec_addr", d[2:0], 3'h0);
      for (int k = 0; k < 7; k++)
      begin
         rd(LV[k]);
         chk("default", d, CLP_DEFAULT[k]);
         v = 16'($urandom);
         wr(LV[k], v, 4'hF);
         m0 = k == 0 ? v & CLP_MASK[0] : m0;
         chk("level", lvl[k], v & CLP_MASK[k]);
      end
      wr(CLP_REG_MIC, 16'h0040, 4'hF);
      chk("boost", boost, 1'b1);
      wr(CLP_REG_MIC, 16'h801F, 4'h1);
      chk("strobe", {boost, lvl[3]}, {1'b0, 16'h001F});
      wr(CLP_REG_GENERAL, 16'h2300, 4'hF);
      chk("ctl", {widen, monom, micb}, 3'h7);
      wr(CLP_REG_WIDEN, 16'($urandom), 4'hF);
      chk("depth", {widen, r}, {1'b1, CLP_RESP_OKAY});
      wr(7'h30, 16'hFFFF, 4'hF);
      chk("unmapped_wr", r, CLP_RESP_SLVERR);
      rd(7'h30);
      chk("unmapped_rd", {r, d}, {CLP_RESP_SLVERR, 16'h0});
      wr(CLP_REG_POWER, 16'h8000, 4'hF);
      rd(CLP_REG_POWER);
      chk("amp_pd", {ext_amp_powerdown, d}, {1'b1, 16'h800F});
      head <= {16'hC000, 1'b1, CLP_REG_MASTER, 32'h0};
      repeat (3) @(frames);
      chk("reply", rx, {16'hE000, 1'b0, LV[0], 12'h0, m0, 4'h0});
      head <= {16'hE000, 1'b0, CLP_REG_POWER, 32'h0};
      repeat (3) @(frames);
      chk("link_wr", ext_amp_powerdown, 1'b0);
      head <= '0;
      rstn <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("link_rst", {lvl[0], widen}, {16'h8000, 1'b0});
      {rstn, chain} <= 2'h3;
      repeat (6) @(posedge mclk);
      wr(CLP_REG_CHAIN, 16'h0001, 4'hF);
      repeat (3) @(frames);
      chk("chain", rx, {56{1'b1}});
      {strap_l, srst} <= 2'h1;
      repeat (2) @(posedge mclk);
      chk("xtal_out", xo, 1'b1);
      srst <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(CLP_REG_LINK_STAT);
      chk("secondary", {oe_n, d[2:0]}, 4'hD);
      repeat (3) @(frames);
      chk("chain_sec", rx, {56{1'b1}});
      tally_and_finish;
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      failures++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
